// File: common/mascs_cfg.svh
// timing, code limits and range constants for the scan sequencer
`ifndef MASCS_CFG_SVH
`define MASCS_CFG_SVH

`define MASCS_CLK_HZ        25000000
`define MASCS_AGG_RATE_HZ   500000
// conversion slot length in core_clk cycles, rounded down; only mascs_rate_tick clamps it to at least one
`define MASCS_SLOT_CYC      (`MASCS_CLK_HZ / `MASCS_AGG_RATE_HZ)
`define MASCS_EXTRA_SLOTS   4'h2
`define MASCS_NUM_SE        16
`define MASCS_NUM_DIFF      8
`define MASCS_DIFF_OFS      4'h8
`define MASCS_CODE_MAX      16'h7fff
`define MASCS_CODE_MIN      16'h8000
`define MASCS_RANGE_RST     2'h0
`define MASCS_LSB_10V_UV    9'h140
`define MASCS_LSB_5V_UV     9'h0a0
`define MASCS_LSB_2V_UV     9'h040
`define MASCS_LSB_1V_UV     9'h020

`endif

// File: common/mascs_pkg.sv
// types shared by the scan sequencer files
package mascs_pkg;
    typedef enum logic [1:0] {RANGE_10V, RANGE_5V, RANGE_2V, RANGE_1V} mascs_range_t;
    typedef enum {ST_IDLE, ST_DELAY, ST_ARM, ST_START, ST_WAIT} mascs_state_t;
endpackage

// File: hw/mascs_rate_tick.sv
// free-running divider giving one enable pulse per conversion slot
`timescale 1ns/1ns
`include "mascs_cfg.svh"
module mascs_rate_tick
    import mascs_pkg::*;
(
    input  wire logic core_clk,  // system clock
    input  wire logic rst,       // synchronous reset, active high
    output logic      slotTick   // one-cycle pulse per slot
);
    localparam int SLOT_CYC = (`MASCS_SLOT_CYC < 1) ? 1 : `MASCS_SLOT_CYC;
    logic [15:0] divCnt_ff;
    logic        slotTick_ff;

    // counter is cleared only by reset and at the end of each slot, never by a scan, so the slot grid stays fixed
    always_ff @(posedge core_clk)
    begin
        if (rst || divCnt_ff == 16'(SLOT_CYC - 1))
            divCnt_ff <= 16'h0000;
        else
            divCnt_ff <= divCnt_ff + 16'h0001;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            slotTick_ff <= 1'b0;
        else
            slotTick_ff <= (divCnt_ff == 16'(SLOT_CYC - 1));
    end

    assign slotTick = slotTick_ff;
endmodule // mascs_rate_tick

// File: hw/mascs_sequencer.sv
// multiplexed converter scan sequencer with per-channel gain ranges
`timescale 1ns/1ns
`include "mascs_cfg.svh"
module mascs_sequencer
    import mascs_pkg::*;
(
    input  wire logic        core_clk,     // system clock
    input  wire logic        rst,          // synchronous reset, active high
    input  wire logic        scanReq,      // pulse: start a scan
    input  wire logic [15:0] scanList,     // channel bit mask
    input  wire logic        diffMode,     // paired input mode
    input  wire logic        cfgWe,        // pulse: write one range entry
    input  wire logic [3:0]  cfgChan,      // channel being configured
    input  wire logic [1:0]  cfgRange,     // range code for that channel
    input  wire logic        adcDone,      // converter result strobe
    input  wire logic [17:0] adcRaw,       // signed raw converter reading
    output logic [3:0]       muxPos,       // positive multiplexer input
    output logic [3:0]       muxNeg,       // negative input in paired mode
    output logic             muxDiff,      // paired mode to front end
    output logic [1:0]       gainSel,      // amplifier range select
    output logic             convStart,    // pulse: start conversion
    output logic             busy,         // scan in progress
    output logic             resValid,     // pulse: result present
    output logic [15:0]      resData,      // 16-bit result code
    output logic [3:0]       resChan,      // channel of the result
    output logic             resOver,      // result was saturated
    output logic [8:0]       resLsbUv,     // step size of result in uV
    output logic             scanDone      // pulse: scan finished
);
    mascs_state_t  state_ff;
    logic          slotTick;
    logic [15:0]   pend_ff;
    logic          diff_ff;
    logic          scanSeen_ff;
    logic [3:0]    extra_ff;
    logic [1:0]    rangeTab_ff [`MASCS_NUM_SE];
    logic [3:0]    muxPos_ff, muxNeg_ff;
    logic [1:0]    gainSel_ff;
    logic          muxDiff_ff, convStart_ff, busy_ff, resValid_ff, resOver_ff, scanDone_ff;
    logic [15:0]   resData_ff;
    logic [3:0]    resChan_ff;
    logic [8:0]    resLsbUv_ff;
    logic [3:0]    nxt_chan;
    logic [15:0]   nxt_sat;
    logic          nxt_over;
    logic [15:0]   listMask;

    mascs_rate_tick mascs_rate_tick_i (
        .core_clk (core_clk),
        .rst      (rst),
        .slotTick (slotTick)
    );

    // per-channel range storage, one entry per input
    genvar g;
    generate
        for (g = 0; g < `MASCS_NUM_SE; g++)
        begin : g_range
            always_ff @(posedge core_clk)
            begin
                if (rst)
                    rangeTab_ff[g] <= `MASCS_RANGE_RST;
                else if (cfgWe && cfgChan == 4'(g))
                    rangeTab_ff[g] <= cfgRange;
            end
        end
    endgenerate

    // paired mode drops the upper half; those inputs are negative legs
    assign listMask = diffMode ? {8'h00, scanList[7:0]} : scanList;

    // lowest pending channel wins, giving ascending order
    always_comb
    begin
        nxt_chan = 4'h0;
        for (int i = `MASCS_NUM_SE - 1; i >= 0; i--)
            if (pend_ff[i])
                nxt_chan = 4'(i);
    end

    // clamp instead of wrap; out-of-span input detail is lost
    always_comb
    begin
        nxt_over = 1'b1;
        if ($signed(adcRaw) > $signed({2'b00, `MASCS_CODE_MAX}))
            nxt_sat = `MASCS_CODE_MAX;
        else if ($signed(adcRaw) < $signed({2'b11, `MASCS_CODE_MIN}))
            nxt_sat = `MASCS_CODE_MIN;
        else
        begin
            nxt_sat  = adcRaw[15:0];
            nxt_over = 1'b0;
        end
    end

    // scan state machine, one conversion per slot tick
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_ff <= ST_IDLE;
        else
            case (state_ff)
                ST_IDLE:  if (scanReq) state_ff <= scanSeen_ff ? ST_DELAY : ST_ARM;
                ST_DELAY: if (slotTick && extra_ff == 4'h1) state_ff <= ST_ARM;
                ST_ARM:   if (pend_ff == 16'h0000) state_ff <= ST_IDLE;
                          else if (slotTick) state_ff <= ST_START;
                ST_START: state_ff <= ST_WAIT;
                ST_WAIT:  if (adcDone) state_ff <= ST_ARM;
                default:  state_ff <= ST_IDLE;
            endcase
    end

    // pending list, mode and extra-delay count
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pend_ff     <= 16'h0000;
            diff_ff     <= 1'b0;
            scanSeen_ff <= 1'b0;
            extra_ff    <= 4'h0;
        end
        else if (state_ff == ST_IDLE && scanReq)
        begin
            pend_ff     <= listMask;
            diff_ff     <= diffMode;
            scanSeen_ff <= 1'b1;
            extra_ff    <= `MASCS_EXTRA_SLOTS;
        end
        else
        begin
            if (state_ff == ST_DELAY && slotTick)
                extra_ff <= extra_ff - 4'h1;
            if (state_ff == ST_WAIT && adcDone)
                pend_ff[muxPos_ff] <= 1'b0;
        end
    end

    // front-end select: mux and gain settle a cycle before the start pulse
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            muxPos_ff  <= 4'h0;
            muxNeg_ff  <= `MASCS_DIFF_OFS;
            muxDiff_ff <= 1'b0;
            gainSel_ff <= `MASCS_RANGE_RST;
        end
        else if (state_ff == ST_ARM && slotTick && pend_ff != 16'h0000)
        begin
            muxPos_ff  <= nxt_chan;
            muxNeg_ff  <= nxt_chan + `MASCS_DIFF_OFS;
            muxDiff_ff <= diff_ff;
            gainSel_ff <= rangeTab_ff[nxt_chan];
        end
    end

    // status pulses and busy level
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            convStart_ff <= 1'b0;
            busy_ff      <= 1'b0;
            scanDone_ff  <= 1'b0;
        end
        else
        begin
            convStart_ff <= (state_ff == ST_START);
            busy_ff      <= (state_ff != ST_IDLE) || scanReq;
            scanDone_ff  <= (state_ff == ST_ARM && pend_ff == 16'h0000);
        end
    end

    // result capture with step size of the range in force
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            resValid_ff <= 1'b0;
            resData_ff  <= 16'h0000;
            resChan_ff  <= 4'h0;
            resOver_ff  <= 1'b0;
            resLsbUv_ff <= `MASCS_LSB_10V_UV;
        end
        else
        begin
            resValid_ff <= (state_ff == ST_WAIT && adcDone);
            if (state_ff == ST_WAIT && adcDone)
            begin
                resData_ff <= nxt_sat;
                resChan_ff <= muxPos_ff;
                resOver_ff <= nxt_over;
                // step sizes already carry the 5 percent headroom
                case (gainSel_ff)
                    RANGE_10V: resLsbUv_ff <= `MASCS_LSB_10V_UV;
                    RANGE_5V:  resLsbUv_ff <= `MASCS_LSB_5V_UV;
                    RANGE_2V:  resLsbUv_ff <= `MASCS_LSB_2V_UV;
                    default:   resLsbUv_ff <= `MASCS_LSB_1V_UV;
                endcase
            end
        end
    end

    assign muxPos    = muxPos_ff;
    assign muxNeg    = muxNeg_ff;
    assign muxDiff   = muxDiff_ff;
    assign gainSel   = gainSel_ff;
    assign convStart = convStart_ff;
    assign busy      = busy_ff;
    assign resValid  = resValid_ff;
    assign resData   = resData_ff;
    assign resChan   = resChan_ff;
    assign resOver   = resOver_ff;
    assign resLsbUv  = resLsbUv_ff;
    assign scanDone  = scanDone_ff;

    // helper: last started channel within the current scan
    logic [3:0] lastChan_ff;
    logic       startedInScan_ff;
    always_ff @(posedge core_clk)
    begin
        if (rst || (state_ff == ST_IDLE))
            startedInScan_ff <= 1'b0;
        else if (convStart_ff)
            startedInScan_ff <= 1'b1;
        if (rst)
            lastChan_ff <= 4'h0;
        else if (convStart_ff)
            lastChan_ff <= muxPos_ff;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_diff_pair: assert property (convStart_ff && muxDiff_ff
        |-> muxNeg_ff == muxPos_ff + `MASCS_DIFF_OFS)
        else $error("paired negative leg not n+8");
    a_diff_low: assert property (convStart_ff && muxDiff_ff |-> muxPos_ff < 4'h8)
        else $error("paired channel above seven");
    a_gain_first: assert property (convStart_ff
        |-> $stable(gainSel_ff) && gainSel_ff == rangeTab_ff[muxPos_ff])
        else $error("gain not settled to channel range at start");
    a_fixed_slot: assert property (convStart_ff |-> $past(slotTick, 2))
        else $error("conversion start off the slot grid");
    a_ascend_order: assert property (convStart_ff && startedInScan_ff
        |-> muxPos_ff > lastChan_ff)
        else $error("channels not ascending");
    a_scan_delay: assert property (state_ff == ST_IDLE && scanReq && scanSeen_ff
        |=> state_ff == ST_DELAY)
        else $error("later scan without extra delay");
    a_range_store: assert property (cfgWe
        |=> rangeTab_ff[$past(cfgChan)] == $past(cfgRange))
        else $error("range entry not stored");
    a_sat_high: assert property (state_ff == ST_WAIT && adcDone
        && $signed(adcRaw) > $signed({2'b00, `MASCS_CODE_MAX})
        |=> resValid_ff && resData_ff == `MASCS_CODE_MAX && resOver_ff)
        else $error("high reading not saturated");
    a_lsb_table: assert property (resValid_ff && $past(gainSel_ff) == RANGE_2V
        |-> resLsbUv_ff == `MASCS_LSB_2V_UV)
        else $error("wrong step size for 2 V range");
endmodule // mascs_sequencer

// File: tb/mascs_conv_model.sv
// converter model: one reading per conversion start after a set lag
`timescale 1ns/1ns
module mascs_conv_model
(
    input  wire logic        core_clk,  // system clock
    input  wire logic        convStart, // start pulse
    input  wire logic [5:0]  lagCyc,    // lag in cycles
    input  wire logic [17:0] rawIn,     // reading to give
    output logic             adcDone,   // result strobe
    output logic [17:0]      adcRaw     // reading bus
);
    logic [5:0] left = 6'h0;
    initial
    begin
        adcDone = 1'b0;
        adcRaw = 18'h0;
    end
    // bus toggles when idle so a stale reading never looks valid
    always @(posedge core_clk)
    begin
        adcDone <= 1'b0;
        adcRaw <= ~adcRaw;
        if (convStart)
            left <= lagCyc;
        else if (left != 6'h0)
            left <= left - 6'h1;
        if (!convStart && left == 6'h1)
        begin
            adcDone <= 1'b1;
            adcRaw <= rawIn;
        end
    end
endmodule // mascs_conv_model

// File: tb/test_mascs_sequencer.sv
// self-checking bench for the scan sequencer with a converter model
`timescale 1ns/1ns
`include "mascs_cfg.svh"
module test_mascs_sequencer;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic scanReq = 1'b0, diffMode = 1'b0, cfgWe = 1'b0;
    logic [15:0] scanList = 16'h0;
    logic [3:0] cfgChan = 4'h0;
    logic [1:0] cfgRange = 2'h0;
    logic [5:0] lagCyc = 6'h1;
    logic [17:0] rawIn = 18'h0;
    logic adcDone, muxDiff, convStart, busy, resValid, resOver, scanDone;
    logic [17:0] adcRaw;
    logic [3:0] muxPos, muxNeg, resChan;
    logic [1:0] gainSel;
    logic [15:0] resData;
    logic [8:0] resLsbUv;
    logic [1:0] rangeOf [16];
    logic [29:0] expQ [$];
    logic [17:0] edgeRaw [4] = '{18'h07fff, 18'h08000, 18'h38000, 18'h37fff};
    int num_errors = 0, comparisons = 0, cyc = 0, lastStart = -1, scans = 0;

    mascs_sequencer mascs_sequencer_i (.core_clk(core_clk), .rst(rst), .scanReq(scanReq),
        .scanList(scanList), .diffMode(diffMode), .cfgWe(cfgWe), .cfgChan(cfgChan),
        .cfgRange(cfgRange), .adcDone(adcDone), .adcRaw(adcRaw), .muxPos(muxPos),
        .muxNeg(muxNeg), .muxDiff(muxDiff), .gainSel(gainSel), .convStart(convStart),
        .busy(busy), .resValid(resValid), .resData(resData), .resChan(resChan),
        .resOver(resOver), .resLsbUv(resLsbUv), .scanDone(scanDone));
    mascs_conv_model mascs_conv_model_i (.core_clk(core_clk), .convStart(convStart),
        .lagCyc(lagCyc), .rawIn(rawIn), .adcDone(adcDone), .adcRaw(adcRaw));

    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    task automatic chkRes(input logic [29:0] got, input logic [29:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkCtl(input logic [7:0] got, input logic [7:0] exp);
        chkRes({22'h0, got}, {22'h0, exp});
    endtask

    function automatic logic [8:0] lsbOf(input logic [1:0] r);
        return r == 2'h0 ? `MASCS_LSB_10V_UV : r == 2'h1 ? `MASCS_LSB_5V_UV :
               r == 2'h2 ? `MASCS_LSB_2V_UV : `MASCS_LSB_1V_UV;
    endfunction

    // results are paired with the oldest note as they appear
    always @(negedge core_clk)
    begin
        if (resValid)
            chkRes({resChan, resOver, resData, resLsbUv},
                   expQ.size() != 0 ? expQ.pop_front() : 30'hx);
        if (convStart)
        begin
            chkCtl({5'h0, muxDiff, gainSel}, {5'h0, diffMode, rangeOf[muxPos]});
            chkCtl({4'h0, muxNeg}, {4'h0, muxPos + 4'h8});
            if (lastStart >= 0)
                chkCtl(8'(cyc - lastStart), 8'(`MASCS_SLOT_CYC));
            lastStart = cyc;
        end
        // the gap check restarts with each scan
        if (scanDone)
            lastStart = -1;
    end

    // one scan: note results, request, poke while busy unless the list is empty, wait for idle
    task automatic runScan(input logic [15:0] lst, input logic dm, input logic [17:0] raw,
                           input logic [5:0] lag);
        logic ovr;
        logic ok;
        logic [15:0] dat;
        int n;
        int dn;
        ovr = ($signed(raw) > 32767) || ($signed(raw) < -32768);
        dat = !ovr ? raw[15:0] : (raw[17] ? 16'h8000 : 16'h7fff);
        n = 0;
        dn = 0;
        @(negedge core_clk);
        scanList = dm ? {8'h00, lst[7:0]} : lst;
        for (int c = 0; c < 16; c++)
            if (scanList[c])
                expQ.push_back({4'(c), ovr, dat, lsbOf(rangeOf[c])});
        diffMode = dm;
        rawIn = raw;
        lagCyc = lag;
        scanReq = 1'b1;
        @(negedge core_clk);
        scanReq = 1'b0;
        if (scanList != 16'h0)
        begin
            while (!convStart && n < 200)
            begin
                @(negedge core_clk);
                n++;
            end
            ok = scans == 0 ? n <= `MASCS_SLOT_CYC + 5
                            : n >= `MASCS_EXTRA_SLOTS * `MASCS_SLOT_CYC
                              && n <= (`MASCS_EXTRA_SLOTS + 1) * `MASCS_SLOT_CYC + 5;
            chkCtl({7'h0, ok}, 8'h1);
            scanReq = 1'b1;
            @(negedge core_clk);
            scanReq = 1'b0;
        end
        while (busy && n < 2000)
        begin
            if (scanDone)
                dn++;
            @(negedge core_clk);
            n++;
        end
        chkCtl({7'h0, busy}, 8'h0);
        chkCtl(8'(dn), 8'h1);
        chkCtl(8'(expQ.size()), 8'h0);
        scans++;
        $display("scan %0d done, list %h", scans, scanList);
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // watchdog sized well beyond six scans of sixteen slots
    initial
    begin
        #800000;
        num_errors++;
        complete_run;
    end

    initial
    begin
        logic [1:0] rot;
        logic [15:0] rnd;
        void'($urandom(58036));
        rot = 2'($urandom);
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        chkCtl({muxNeg, muxPos}, 8'h80);
        // every channel gets its own range, written back to back
        for (int c = 0; c < 16; c++)
        begin
            @(negedge core_clk);
            cfgWe = 1'b1;
            cfgChan = 4'(c);
            cfgRange = 2'(c) ^ rot;
            rangeOf[c] = cfgRange;
        end
        @(negedge core_clk);
        cfgWe = 1'b0;
        $display("range setup done");
        rnd = 16'($urandom);
        runScan(rnd | 16'h8001, 1'b0, {{2{rnd[15]}}, rnd}, 6'h1);
        runScan(16'h0, 1'b0, 18'h0, 6'h1);
        // saturation edges, alternating paired mode, slow converter on the last two
        for (int i = 0; i < 4; i++)
            runScan(16'($urandom) | 16'h0001, i[0], edgeRaw[i], i[1] ? 6'h28 : 6'h2);
        complete_run;
    end
endmodule // test_mascs_sequencer
